// File: rtl/lsd_driver.sv
// Segment LCD driver control: control bits, nibble display memory, common scan,
// segment on/off decision and DC output pins.
// Assumes a plain register port and that the drive voltage levels are produced
// outside from the on/select/polarity outputs.
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps

module lsd_driver #(
    parameter lsd_pkg::lsd_supply_t SUPPLY = lsd_pkg::LSD_SUP_INTERNAL,
    parameter logic [lsd_pkg::NUM_SEG*lsd_pkg::NUM_COM*lsd_pkg::MAP_W-1:0] SEG_MAP = lsd_pkg::lsd_default_map(),
    parameter logic [lsd_pkg::NUM_PAIR-1:0] PAIR_DC = 28'h0000000,
    parameter logic [lsd_pkg::NUM_SEG-1:0] OPEN_DRAIN = 56'h00000000000000
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Register port
    input wire logic [15:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [3:0] reg_rdata,
    // Panel side
    output logic [7:0] common_outputs,
    output logic [55:0] segment_outputs,
    output logic frame_polarity,
    output logic static_mode,
    output logic lcd_voltage_power_on,
    // DC pins
    output logic [55:0] seg_dc_out,
    output logic [55:0] seg_dc_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Build-time masks

    // static only on the half-bias external supply
    localparam logic STATIC_OK = (SUPPLY == lsd_pkg::LSD_SUP_EXT_HALF);

    logic [55:0] dc_mask;
    logic [55:0] wave_mask;

    // pins 2n and 2n+1 share one choice
    always_comb begin
        for (int p = 0; p < lsd_pkg::NUM_PAIR; p++) begin
            dc_mask[2*p] = PAIR_DC[p];
            dc_mask[2*p+1] = PAIR_DC[p];
        end
        wave_mask = ~dc_mask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Display memory, deliberately without reset

    logic [3:0] mem [lsd_pkg::MEM_WORDS];
    logic mem_hit;
    logic [7:0] mem_idx;

    always_comb begin
        mem_hit = (reg_addr >= lsd_pkg::MEM_BASE) && (reg_addr <= lsd_pkg::MEM_LAST);
        mem_idx = reg_addr[7:0];
    end

    // contents stay unknown until software writes them
    // every word writable, mapped or not
    always_ff @(posedge clk_sys) begin
        if (reg_wr && mem_hit) begin
            mem[mem_idx] <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded memory bits per segment and slot

    logic [7:0] slot_bits [lsd_pkg::NUM_SEG];

    // each slot reads its chosen word and bit
    always_comb begin
        logic [9:0] ent;
        ent = '0;
        for (int g = 0; g < lsd_pkg::NUM_SEG; g++) begin
            for (int s = 0; s < lsd_pkg::NUM_COM; s++) begin
                ent = SEG_MAP[(g*lsd_pkg::NUM_COM+s)*lsd_pkg::MAP_W +: lsd_pkg::MAP_W];
                slot_bits[g][s] = (ent[9:2] < 8'(lsd_pkg::MEM_WORDS)) ? mem[ent[9:2]][ent[1:0]] : 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State

    lsd_pkg::lsd_state_t st;
    lsd_pkg::lsd_state_t next_st;

    logic osc_tick;
    logic [8:0] slot_ticks;
    logic [2:0] last_com;
    logic [25:0] acc_sum;

    // slot length gives 32/25/32 Hz frames
    always_comb begin
        if (st.duty_hi) begin
            slot_ticks = lsd_pkg::SLOT_TICKS_8;
            last_com = lsd_pkg::LAST_COM_8;
        end else if (st.duty_lo) begin
            slot_ticks = lsd_pkg::SLOT_TICKS_5;
            last_com = lsd_pkg::LAST_COM_5;
        end else begin
            slot_ticks = lsd_pkg::SLOT_TICKS_4;
            last_com = lsd_pkg::LAST_COM_4;
        end
    end

    // Fractional divider: 32.768 kHz enable from 25 MHz without drift
    always_comb begin
        acc_sum = {1'b0, st.acc} + {1'b0, lsd_pkg::ACC_STEP};
        osc_tick = (acc_sum >= {1'b0, lsd_pkg::ACC_WRAP});
    end

    always_comb begin
        logic on_bit;
        on_bit = 1'b0;
        next_st = st;
        next_st.rdata = 4'h0;

        // Register writes
        if (reg_wr && reg_addr == lsd_pkg::CTRL_ADDR) begin
            next_st.force_on = reg_wdata[lsd_pkg::CTRL_ON_BIT];
            next_st.force_off = reg_wdata[lsd_pkg::CTRL_OFF_BIT];
            next_st.static_req = reg_wdata[lsd_pkg::CTRL_STATIC_BIT];
            next_st.pwr = reg_wdata[lsd_pkg::CTRL_PWR_BIT];
        end
        if (reg_wr && reg_addr == lsd_pkg::DUTY_ADDR) begin
            next_st.duty_hi = reg_wdata[lsd_pkg::DUTY_HI_BIT];
            next_st.duty_lo = reg_wdata[lsd_pkg::DUTY_LO_BIT];
        end

        // Register reads, data in the following cycle; unmapped reads give zero
        if (reg_rd) begin
            if (mem_hit) begin
                next_st.rdata = mem[mem_idx];
            end else if (reg_addr == lsd_pkg::CTRL_ADDR) begin
                next_st.rdata = {st.pwr, st.static_req, st.force_off, st.force_on};
            end else if (reg_addr == lsd_pkg::DUTY_ADDR) begin
                next_st.rdata = {2'h0, st.duty_hi, st.duty_lo};
            end else if (reg_addr == lsd_pkg::STAT_ADDR) begin
                next_st.rdata = {st.frame_pol, st.com_idx};
            end
        end

        // Common scan
        if (osc_tick) begin
            next_st.acc = 25'(acc_sum - {1'b0, lsd_pkg::ACC_WRAP});
        end else begin
            next_st.acc = acc_sum[24:0];
        end
        // index past the last common after a duty change restarts at once
        if (st.com_idx > last_com) begin
            next_st.com_idx = 3'h0;
            next_st.tcnt = 9'h000;
        end else if (osc_tick) begin
            if (st.tcnt >= slot_ticks - 9'h001) begin
                next_st.tcnt = 9'h000;
                if (st.com_idx == last_com) begin
                    next_st.com_idx = 3'h0;
                    next_st.frame_pol = ~st.frame_pol;
                end else begin
                    next_st.com_idx = st.com_idx + 3'h1;
                end
            end else begin
                next_st.tcnt = st.tcnt + 9'h001;
            end
        end

        // static mode needs the bit and the supply option
        // otherwise the bit has no effect
        next_st.static_mode = st.static_req && STATIC_OK;

        // no generator, no common or segment drive
        if (!st.pwr) begin
            next_st.com_sel = 8'h00;
        end else if (st.static_mode) begin
            next_st.com_sel = 8'hFF;
        end else begin
            next_st.com_sel = 8'h01 << st.com_idx;
        end

        for (int g = 0; g < lsd_pkg::NUM_SEG; g++) begin
            // any slot bit set lights the static segment
            // memory one is on, zero is off
            if (st.static_mode) begin
                on_bit = |slot_bits[g];
            end else begin
                on_bit = slot_bits[g][st.com_idx];
            end
            if (!st.pwr || dc_mask[g]) begin
                next_st.seg_on[g] = 1'b0;
            end else if (st.force_on) begin
                next_st.seg_on[g] = 1'b1;
            end else if (st.force_off) begin
                next_st.seg_on[g] = 1'b0;
            end else begin
                next_st.seg_on[g] = on_bit;
            end
            // DC pin shows its common-0 bit
            // independent of power and force bits
            if (!dc_mask[g]) begin
                next_st.dc_out[g] = 1'b0;
                next_st.dc_oe[g] = 1'b0;
            end else if (OPEN_DRAIN[g]) begin
                next_st.dc_out[g] = 1'b0;
                next_st.dc_oe[g] = ~slot_bits[g][0];
            end else begin
                next_st.dc_out[g] = slot_bits[g][0];
                next_st.dc_oe[g] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.force_on <= lsd_pkg::CTRL_RESET[lsd_pkg::CTRL_ON_BIT];
            st.force_off <= lsd_pkg::CTRL_RESET[lsd_pkg::CTRL_OFF_BIT];
            st.static_req <= lsd_pkg::CTRL_RESET[lsd_pkg::CTRL_STATIC_BIT];
            st.pwr <= lsd_pkg::CTRL_RESET[lsd_pkg::CTRL_PWR_BIT];
            st.duty_hi <= lsd_pkg::DUTY_RESET[lsd_pkg::DUTY_HI_BIT];
            st.duty_lo <= lsd_pkg::DUTY_RESET[lsd_pkg::DUTY_LO_BIT];
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    // generator enable follows the power bit
    assign lcd_voltage_power_on = st.pwr;
    assign reg_rdata = st.rdata;
    assign common_outputs = st.com_sel;
    assign segment_outputs = st.seg_on;
    assign frame_polarity = st.frame_pol;
    assign static_mode = st.static_mode;
    assign seg_dc_out = st.dc_out;
    assign seg_dc_oe = st.dc_oe;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // Slot length counter for the frame rate check
    logic [17:0] slot_len;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slot_len <= 18'h00000;
        end else if (st.com_idx != next_st.com_idx) begin
            slot_len <= 18'h00000;
        end else if (slot_len != 18'h3FFFF) begin
            slot_len <= slot_len + 18'h00001;
        end
    end

    chk_force_on_all: assert property (st.force_on && st.pwr |=> (segment_outputs & wave_mask) == wave_mask)
        else $error("force on did not light all segments");
    chk_force_off_all: assert property (st.force_off && !st.force_on && st.pwr |=> (segment_outputs & wave_mask) == 56'h0)
        else $error("force off did not blank segments");
    chk_force_priority: assert property (st.force_on && st.force_off && st.pwr |=> (segment_outputs & wave_mask) != 56'h0 || wave_mask == 56'h0)
        else $error("all-off won over all-on");
    chk_duty_span: assert property (!$past(st.duty_hi) && !$past(st.duty_lo) |-> st.com_idx <= 3'h3)
        else $error("1/4 duty scanned past common 3");
    chk_slot_time: assert property (st.duty_hi && st.pwr && st.com_idx != next_st.com_idx && st.com_idx != 3'h0 |-> slot_len < 18'h17ED0)
        else $error("common slot too long at 1/8 duty");
    chk_static_gate: assert property (!STATIC_OK |-> !static_mode)
        else $error("static mode without half-bias supply");
    chk_power_blank: assert property (!st.pwr |=> common_outputs == 8'h00 ##0 (segment_outputs & wave_mask) == 56'h0)
        else $error("drive active with power off");
    chk_dc_only: assert property ((seg_dc_oe & wave_mask) == 56'h0 && (segment_outputs & dc_mask) == 56'h0)
        else $error("pin driven in wrong output type");
    chk_ctrl_read: assert property (reg_rd && reg_addr == lsd_pkg::CTRL_ADDR && !reg_wr |=>
        reg_rdata == {$past(st.pwr), $past(st.static_req), $past(st.force_off), $past(st.force_on)})
        else $error("control read-back mismatch");
    chk_com_onehot: assert property (st.pwr && !st.static_mode |=> $onehot(common_outputs) || $past(st.static_mode))
        else $error("common select not one-hot");

    // reference tick spacing
    // Saturates, so a lost tick stays visible instead of wrapping
    logic [9:0] tick_gap;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tick_gap <= 10'h000;
        end else if (osc_tick) begin
            tick_gap <= 10'h000;
        end else if (tick_gap != 10'h3FF) begin
            tick_gap <= tick_gap + 10'h001;
        end
    end

    chk_tick_gap: assert property (tick_gap <= 10'(lsd_pkg::SYS_HZ / lsd_pkg::OSC_HZ)
        && (!osc_tick || tick_gap >= 10'(lsd_pkg::SYS_HZ / lsd_pkg::OSC_HZ - 1)))
        else $error("reference tick spacing off");
    chk_tcnt_bound: assert property (st.tcnt < lsd_pkg::SLOT_TICKS_5)
        else $error("slot tick counter past longest slot");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 4'h0)
        else $error("read data stood longer than one cycle");
    chk_ctrl_write: assert property (reg_wr && reg_addr == lsd_pkg::CTRL_ADDR |=>
        st.force_on == $past(reg_wdata[lsd_pkg::CTRL_ON_BIT]) && st.force_off == $past(reg_wdata[lsd_pkg::CTRL_OFF_BIT]))
        else $error("force bits did not take the write");
    chk_static_write: assert property (reg_wr && reg_addr == lsd_pkg::CTRL_ADDR |=> ##1
        static_mode == ($past(reg_wdata[lsd_pkg::CTRL_STATIC_BIT], 2) && STATIC_OK))
        else $error("static mode does not follow its request");
    chk_pwr_write: assert property (reg_wr && reg_addr == lsd_pkg::CTRL_ADDR |=> lcd_voltage_power_on == $past(reg_wdata[lsd_pkg::CTRL_PWR_BIT]))
        else $error("power enable does not follow its bit");
    chk_duty_read: assert property (reg_rd && reg_addr == lsd_pkg::DUTY_ADDR && !reg_wr |=>
        reg_rdata == {2'h0, $past(st.duty_hi), $past(st.duty_lo)})
        else $error("duty read-back mismatch");
    chk_stat_read: assert property (reg_rd && reg_addr == lsd_pkg::STAT_ADDR && !reg_wr |=>
        reg_rdata == {$past(st.frame_pol), $past(st.com_idx)})
        else $error("status read-back mismatch");
    chk_duty5_span: assert property (!$past(st.duty_hi) && $past(st.duty_lo) |-> st.com_idx <= 3'h4)
        else $error("1/5 duty scanned past common 4");
    chk_static_coms: assert property (st.static_mode && st.pwr |=> common_outputs == 8'hFF)
        else $error("static mode did not select every common");
    chk_frame_wrap: assert property ($changed(st.frame_pol) |-> st.com_idx == 3'h0)
        else $error("frame polarity flipped away from a wrap");
    chk_dc_drive: assert property ($past(arst_n) |->
        (seg_dc_oe & dc_mask & ~OPEN_DRAIN) == (dc_mask & ~OPEN_DRAIN))
        else $error("complementary DC pin released");
    chk_od_low: assert property ((seg_dc_out & OPEN_DRAIN) == 56'h0)
        else $error("open drain pin driven high");

    cov_frame_wrap: cover property (st.com_idx == 3'h7 ##1 st.com_idx == 3'h0);
    cov_duty5_wrap: cover property (st.duty_lo && !st.duty_hi && st.com_idx == 3'h4 ##1 st.com_idx == 3'h0);
    cov_static_on: cover property (static_mode && segment_outputs != 56'h0);
    cov_both_force: cover property (st.force_on && st.force_off && st.pwr);
    cov_tick_seen: cover property (osc_tick);

endmodule

// File: rtl/lsd_pkg.sv
// Package for the segment LCD driver control: register map, field positions,
// reset values, scan timing and the default segment decoder.
// Assumes a 25 MHz system clock and a 32.768 kHz reference for frame timing.
package lsd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int NUM_SEG = 56;
    localparam int NUM_COM = 8;
    localparam int NUM_PAIR = 28;
    localparam int MEM_WORDS = 160;
    localparam int MAP_W = 10;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, 4-bit data
    localparam logic [15:0] MEM_BASE = 16'hF000;
    localparam logic [15:0] MEM_LAST = 16'hF09F;
    localparam logic [15:0] CTRL_ADDR = 16'hF0A0;
    localparam logic [15:0] DUTY_ADDR = 16'hF0A1;
    localparam logic [15:0] STAT_ADDR = 16'hF0A2;

    // Control register fields
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_OFF_BIT = 1;
    localparam int CTRL_STATIC_BIT = 2;
    localparam int CTRL_PWR_BIT = 3;
    // Duty register fields
    localparam int DUTY_LO_BIT = 0;
    localparam int DUTY_HI_BIT = 1;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [1:0] DUTY_RESET = 2'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int SYS_HZ = 25_000_000;
    localparam int OSC_HZ = 32_768;
    localparam int FRAME_HZ_8 = 32;
    localparam int FRAME_HZ_5 = 25;
    localparam int FRAME_HZ_4 = 32;
    localparam logic [24:0] ACC_STEP = 25'(OSC_HZ);
    localparam logic [24:0] ACC_WRAP = 25'(SYS_HZ);
    // Reference ticks per common slot
    localparam logic [8:0] SLOT_TICKS_8 = 9'(OSC_HZ / (FRAME_HZ_8 * 8));
    localparam logic [8:0] SLOT_TICKS_5 = 9'(OSC_HZ / (FRAME_HZ_5 * 5));
    localparam logic [8:0] SLOT_TICKS_4 = 9'(OSC_HZ / (FRAME_HZ_4 * 4));
    localparam logic [2:0] LAST_COM_8 = 3'h7;
    localparam logic [2:0] LAST_COM_5 = 3'h4;
    localparam logic [2:0] LAST_COM_4 = 3'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Supply options
    typedef enum logic [1:0] {
        LSD_SUP_INTERNAL = 2'h0,
        LSD_SUP_EXT_THIRD_45 = 2'h1,
        LSD_SUP_EXT_THIRD_30 = 2'h3,
        LSD_SUP_EXT_HALF = 2'h2
    } lsd_supply_t;

    // Whole block state
    typedef struct packed {
        logic force_on;
        logic force_off;
        logic static_req;
        logic pwr;
        logic duty_hi;
        logic duty_lo;
        logic [3:0] rdata;
        logic [24:0] acc;
        logic [8:0] tcnt;
        logic [2:0] com_idx;
        logic frame_pol;
        logic static_mode;
        logic [7:0] com_sel;
        logic [55:0] seg_on;
        logic [55:0] dc_out;
        logic [55:0] dc_oe;
    } lsd_state_t;

    // Default decoder: segment g, slot s reads linear bit g*8+s
    function automatic logic [NUM_SEG*NUM_COM*MAP_W-1:0] lsd_default_map();
        logic [NUM_SEG*NUM_COM*MAP_W-1:0] m;
        int v;
        m = '0;
        for (int i = 0; i < NUM_SEG * NUM_COM; i++) begin
            v = i;
            m[i*MAP_W +: MAP_W] = {8'(v >> 2), 2'(v & 3)};
        end
        return m;
    endfunction

endpackage

// File: testbench/lsd_panel_model.sv
// Passive segment glass seen from the driver pins: which segments darken and
// what level the DC pins settle to.
// Assumes a board pull-up on every DC pin, as an open drain load needs one.
`timescale 1ns/1ps

module lsd_panel_model (
    // Waveform side
    input wire logic [7:0] common_outputs,
    input wire logic [55:0] segment_outputs,
    input wire logic lcd_voltage_power_on,
    // DC pins
    input wire logic [55:0] seg_dc_out,
    input wire logic [55:0] seg_dc_oe,
    // Observed glass
    output logic [55:0] pixels_lit,
    output logic [55:0] dc_level
);
    ////////////////////////////////////////////////////////////////////////////
    // No drive voltage or no common selected leaves the glass clear
    assign pixels_lit = (lcd_voltage_power_on && (common_outputs != 8'h00)) ? segment_outputs : 56'h0;
    // Released pins float to the pull-up, never to the last driven value
    assign dc_level = (seg_dc_oe & seg_dc_out) | ~seg_dc_oe;
endmodule

// File: testbench/testbench.sv
// Self-checking bench for the segment LCD driver control.
// Assumes the plain register port with read data one cycle after the strobe,
// and a half-bias build with pins 0/1 as DC (pin 1 open drain).
`timescale 1ns/1ps

module testbench;
    localparam logic [55:0] WAVE_PINS = 56'hFFFFFFFFFFFFFC;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [3:0] reg_wdata = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_rdata;
    logic [7:0] common_outputs;
    logic [55:0] segment_outputs, seg_dc_out, seg_dc_oe, pixels_lit, dc_level;
    logic frame_polarity, static_mode, lcd_voltage_power_on, int_static;
    logic [3:0] mem [160];
    logic [3:0] rd;
    logic [55:0] want;
    int error_cnt = 0;
    int checks = 0;

    always #20 clk_sys = ~clk_sys;

    lsd_driver #(.SUPPLY(lsd_pkg::LSD_SUP_EXT_HALF), .PAIR_DC(28'h0000001),
        .OPEN_DRAIN(56'h00000000000002)) uut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .common_outputs(common_outputs), .segment_outputs(segment_outputs), .frame_polarity(frame_polarity),
        .static_mode(static_mode), .lcd_voltage_power_on(lcd_voltage_power_on), .seg_dc_out(seg_dc_out),
        .seg_dc_oe(seg_dc_oe));
    // Internal supply build: the static request must stay without effect
    lsd_driver uut_int (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(), .common_outputs(), .segment_outputs(),
        .frame_polarity(), .static_mode(int_static), .lcd_voltage_power_on(), .seg_dc_out(), .seg_dc_oe());
    lsd_panel_model panel (.common_outputs(common_outputs), .segment_outputs(segment_outputs),
        .lcd_voltage_power_on(lcd_voltage_power_on), .seg_dc_out(seg_dc_out), .seg_dc_oe(seg_dc_oe),
        .pixels_lit(pixels_lit), .dc_level(dc_level));

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmp_vec(logic [55:0] got, logic [55:0] exp_v);
        checks++;
        if (got !== exp_v) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp_v);
        end
    endtask

    task automatic cmp_nib(logic [3:0] got, logic [3:0] exp_v);
        checks++;
        if (got !== exp_v) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp_v);
        end
    endtask

    task automatic reg_write(logic [15:0] addr, logic [3:0] data);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_wdata <= data;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    // Data is taken in the single cycle it stands
    task automatic reg_read(logic [15:0] addr, output logic [3:0] data);
        @(posedge clk_sys);
        reg_addr <= addr;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        data = reg_rdata;
    endtask

    // Pin outputs follow a write two cycles later
    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    function automatic logic seg_bit(int g, int s);
        return mem[(g * 8 + s) / 4][(g * 8 + s) % 4];
    endfunction

    task automatic calc_normal();
        for (int g = 0; g < 56; g++) begin
            want[g] = seg_bit(g, 0);
        end
        want[1:0] = 2'b00;
    endtask

    // Pin 0 complementary, pin 1 open drain, both showing their slot 0 bit
    task automatic check_dc();
        logic b0, b1;
        b0 = seg_bit(0, 0);
        b1 = seg_bit(1, 0);
        cmp_vec(56'({seg_dc_oe[1:0], seg_dc_out[1:0], dc_level[1:0]}), 56'({~b1, 1'b1, 1'b0, b0, b1, b0}));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        reg_read(lsd_pkg::CTRL_ADDR, rd);
        cmp_nib(rd, lsd_pkg::CTRL_RESET);
        reg_read(lsd_pkg::STAT_ADDR, rd);
        cmp_nib(rd, 4'h0);
        cmp_vec(56'(common_outputs), 56'h0);
        $display("test reset done");
        for (int w = 0; w < 160; w++) begin
            mem[w] = (w % 5 < 2) ? 4'h0 : 4'(w * 7 + 1);
            reg_write(lsd_pkg::MEM_BASE + 16'(w), mem[w]);
        end
        for (int w = 0; w < 160; w++) begin
            reg_read(lsd_pkg::MEM_BASE + 16'(w), rd);
            cmp_nib(rd, mem[w]);
        end
        reg_read(16'hF0B0, rd);
        cmp_nib(rd, 4'h0);
        $display("test memory done");
        // Force codes: on, off, both, none
        for (int i = 0; i < 4; i++) begin
            reg_write(lsd_pkg::CTRL_ADDR, 4'h9 + 4'(i % 3));
            if (i == 3) reg_write(lsd_pkg::CTRL_ADDR, 4'h8);
            settle();
            calc_normal();
            if (i == 0 || i == 2) want = WAVE_PINS;
            if (i == 1) want = 56'h0;
            cmp_vec(segment_outputs, want);
            cmp_vec(pixels_lit, want);
            cmp_vec(56'(common_outputs), 56'h1);
            cmp_vec(56'(lcd_voltage_power_on), 56'h1);
            check_dc();
        end
        $display("test force done");
        for (int i = 0; i < 4; i++) begin
            reg_write(lsd_pkg::DUTY_ADDR, 4'(2 - i + 4 * (i / 3)));
            reg_read(lsd_pkg::DUTY_ADDR, rd);
            cmp_nib(rd, 4'(2 - i + 4 * (i / 3)));
            cmp_vec(56'(common_outputs), 56'h1);
        end
        // A 1/8 slot spans 128 reference ticks, so a few ticks leave common 0 selected
        repeat (1600) @(posedge clk_sys);
        reg_read(lsd_pkg::STAT_ADDR, rd);
        cmp_nib(rd, 4'h0);
        cmp_vec(56'(frame_polarity), 56'h0);
        $display("test duty done");
        reg_write(lsd_pkg::CTRL_ADDR, 4'hC);
        settle();
        for (int g = 0; g < 56; g++) begin
            want[g] = |{mem[2 * g], mem[2 * g + 1]};
        end
        want[1:0] = 2'b00;
        cmp_vec(56'({static_mode, int_static}), 56'h2);
        cmp_vec(56'(common_outputs), 56'hFF);
        cmp_vec(segment_outputs, want);
        $display("test static done");
        reg_write(lsd_pkg::CTRL_ADDR, 4'h0);
        // Flip both DC bits so the driven-high and pulled-low levels are seen too
        mem[0] = 4'h1;
        mem[2] = 4'h0;
        reg_write(lsd_pkg::MEM_BASE, mem[0]);
        reg_write(lsd_pkg::MEM_BASE + 16'h0002, mem[2]);
        settle();
        cmp_vec(56'({lcd_voltage_power_on, static_mode, common_outputs}), 56'h0);
        cmp_vec(segment_outputs, 56'h0);
        check_dc();
        $display("test power off done");
        report_and_stop();
    end
endmodule
